//--- logic/sc2_mode_ctrl.sv
// Contract
// - reference 0: master clock, rate register and 8/7 bit, phase shift allowed, video ignored
// - reference 1: lock to sync input, rate from video bit and field, no shift
// - sync-referenced: eight-sevenths bit and generator one registers ignored
// - sync mode: video 0 locks to sync with bit clock, video 1 drops bit clock
// - loop gain bit: 0 finite, 1 infinite; software should keep 0
// - plus bit adds 200 Hz to bit clock pin only, not in video mode
// - eight-sevenths bit with master reference scales conversion rate by 8/7
// - conversion pin runs at 128 times conversion rate when multiplier bit set
// - low nibble n up to 1011 gives (n+1) times 2400 Hz; 1100-1110 reserved
// - bit clock scales by actual over encoded conversion rate
// - both nibbles 1111 give bit clock at 128 times conversion rate
// - video conversion rate is selected base divided by low nibble plus one
// - reset value 00ff, held and write-protected while reset or power-down low
module sc2_mode_ctrl (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic power_down_pin_n_i,
  input wire logic gen2_sync_input_i,
  input wire logic [15:0] gen2_rate_reg_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic gen2_reference_select_o,
  output logic gen2_video_lock_enable_o,
  output logic gen2_loop_gain_select_o,
  output logic gen2_conv_pin_multiplier_o,
  output logic gen2_phase_shift_enable_o,
  output logic gen1_regs_ignored_o,
  output logic gen2_bitclk_enable_o,
  output logic [23:0] gen2_bitclk_hz_o,
  output logic [23:0] gen2_conv_hz_o,
  output logic [23:0] gen2_conv_pin_hz_o,
  output logic [23:0] gen2_video_base_hz_o,
  output logic [4:0] gen2_video_divisor_o,
  output logic gen2_video_pal_o,
  output logic gen2_phase_align_o
);
  logic [15:0] mode_r;
  logic wait_r;
  logic pdn_s;
  logic sync_s;
  logic sync_d_r;
  logic sync_rise;
  logic sync_seen_r;
  logic [23:0] period_cnt_r;
  logic [23:0] period_r;
  logic held;
  logic accept;
  logic wr_mode;
  logic [15:0] be_mask;
  logic [31:0] status_word;
  sc2_pkg::sc2_mode_t mode_q_r;
  logic reserved_q_r;
  logic illegal_q_r;

  sc2_dec_if dif ();

  // pin inputs cross into the system clock
  sc2_sync2ff #(
    .W(2)
  ) u_sync (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .d_i({power_down_pin_n_i, gen2_sync_input_i}),
    .q_o({pdn_s, sync_s})
  );

  sc2_mode_decode u_dec (
    .d(dif.dec)
  );

  assign dif.field = mode_r[sc2_pkg::FLD_MSB:0];
  assign dif.ref_sel = mode_r[sc2_pkg::BIT_REF];
  assign dif.vid = mode_r[sc2_pkg::BIT_VID];
  assign dif.p200 = mode_r[sc2_pkg::BIT_P200];
  assign dif.x87 = mode_r[sc2_pkg::BIT_X87];
  assign dif.rate = gen2_rate_reg_i;

  assign held = !pdn_s;
  assign accept = (avs_read_i || avs_write_i) && wait_r;
  assign wr_mode = avs_write_i && !wait_r && (avs_address_i == sc2_pkg::OFF_MODE);
  assign be_mask = {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
  assign sync_rise = sync_s && !sync_d_r;

  // one wait state: answer registered, then released for one edge
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      wait_r <= 1'b1;
    end else if (accept) begin
      wait_r <= 1'b0;
    end else begin
      wait_r <= 1'b1;
    end
  end

  assign avs_waitrequest_o = wait_r;

  // mode register
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i || held) begin
      mode_r <= sc2_pkg::MODE_RESET;
    end else if (wr_mode) begin
      // reserved bits dropped so reads stay zero regardless of writes
      mode_r <= (mode_r & ~(be_mask & sc2_pkg::MODE_WRITABLE)) |
                (avs_writedata_i[15:0] & be_mask & sc2_pkg::MODE_WRITABLE);
    end
  end

  always_comb begin
    status_word = 32'h0;
    status_word[sc2_pkg::ST_RESERVED] = reserved_q_r;
    status_word[sc2_pkg::ST_ILLEGAL] = illegal_q_r;
    status_word[sc2_pkg::ST_BITCLK] = gen2_bitclk_enable_o;
    status_word[sc2_pkg::ST_MODE_LO +: 2] = mode_q_r;
    status_word[sc2_pkg::ST_HELD] = held;
    status_word[sc2_pkg::ST_SYNC_SEEN] = sync_seen_r;
  end

  // read data loaded on acceptance, stable through the answer edge
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      avs_readdata_o <= 32'h0;
    end else if (accept && avs_read_i) begin
      unique case (avs_address_i)
        sc2_pkg::OFF_MODE: avs_readdata_o <= {16'h0, mode_r};
        sc2_pkg::OFF_STATUS: avs_readdata_o <= status_word;
        sc2_pkg::OFF_SYNC_PERIOD: avs_readdata_o <= {8'h0, period_r};
        default: avs_readdata_o <= 32'h0;
      endcase
    end
  end

  // sync edge detect and period measure in system clocks
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      sync_d_r <= 1'b0;
    end else begin
      sync_d_r <= sync_s;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      period_cnt_r <= 24'h0;
      period_r <= 24'h0;
      sync_seen_r <= 1'b0;
    end else if (sync_rise) begin
      period_cnt_r <= 24'h1;
      period_r <= period_cnt_r;
      sync_seen_r <= 1'b1;
    end else if (period_cnt_r != 24'hffffff) begin
      // saturates so the next edge after a very long gap loads all ones, not a wrapped value; a stopped sync keeps the last period
      period_cnt_r <= period_cnt_r + 24'h1;
    end
  end

  // conversion phase follows the sync input only when referenced to it
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      gen2_phase_align_o <= 1'b0;
    end else begin
      gen2_phase_align_o <= sync_rise && mode_r[sc2_pkg::BIT_REF];
    end
  end

  // mode controls
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      gen2_reference_select_o <= 1'b0;
      gen2_video_lock_enable_o <= 1'b0;
      gen2_loop_gain_select_o <= 1'b0;
      gen2_conv_pin_multiplier_o <= 1'b0;
      gen2_phase_shift_enable_o <= 1'b1;
      gen1_regs_ignored_o <= 1'b0;
    end else begin
      gen2_reference_select_o <= mode_r[sc2_pkg::BIT_REF];
      // video bit has no effect with the master reference
      gen2_video_lock_enable_o <= mode_r[sc2_pkg::BIT_REF] && mode_r[sc2_pkg::BIT_VID];
      gen2_loop_gain_select_o <= mode_r[sc2_pkg::BIT_PLLG];
      gen2_conv_pin_multiplier_o <= mode_r[sc2_pkg::BIT_C128];
      gen2_phase_shift_enable_o <= !mode_r[sc2_pkg::BIT_REF];
      gen1_regs_ignored_o <= mode_r[sc2_pkg::BIT_REF];
    end
  end

  // decoded rates
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      gen2_bitclk_enable_o <= 1'b0;
      gen2_bitclk_hz_o <= 24'h0;
      gen2_conv_hz_o <= 24'h0;
      gen2_conv_pin_hz_o <= 24'h0;
      mode_q_r <= sc2_pkg::SC2_MASTER;
      reserved_q_r <= 1'b0;
      illegal_q_r <= 1'b0;
    end else begin
      gen2_bitclk_enable_o <= dif.bitclk_on;
      gen2_bitclk_hz_o <= dif.bitclk_hz;
      gen2_conv_hz_o <= dif.conv_hz;
      if (mode_r[sc2_pkg::BIT_C128]) begin
        gen2_conv_pin_hz_o <= 24'(dif.conv_hz << sc2_pkg::MULT128_SHIFT);
      end else begin
        gen2_conv_pin_hz_o <= dif.conv_hz;
      end
      mode_q_r <= dif.mode;
      reserved_q_r <= dif.code_reserved;
      illegal_q_r <= dif.pair_illegal;
    end
  end

  // video base and divisor, zero outside video lock
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      gen2_video_base_hz_o <= 24'h0;
      gen2_video_divisor_o <= 5'h0;
      gen2_video_pal_o <= 1'b0;
    end else if (dif.mode == sc2_pkg::SC2_SYNC_VIDEO) begin
      gen2_video_base_hz_o <= dif.base_hz;
      gen2_video_divisor_o <= dif.divisor;
      gen2_video_pal_o <= dif.pal;
    end else begin
      gen2_video_base_hz_o <= 24'h0;
      gen2_video_divisor_o <= 5'h0;
      gen2_video_pal_o <= 1'b0;
    end
  end
endmodule : sc2_mode_ctrl

//--- pkg/sc2_pkg.sv
package sc2_pkg;
  localparam int unsigned REG_W = 16;
  localparam int unsigned HZ_W = 24;
  localparam int unsigned DIV_W = 5;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned PERIOD_W = 24;

  // byte offsets of the slave
  localparam logic [3:0] OFF_MODE = 4'h0;
  localparam logic [3:0] OFF_STATUS = 4'h4;
  localparam logic [3:0] OFF_SYNC_PERIOD = 4'h8;

  localparam logic [15:0] MODE_RESET = 16'h00ff;
  // reserved bits 9:8 never stored
  localparam logic [15:0] MODE_WRITABLE = 16'hfcff;

  localparam int unsigned BIT_REF = 15;
  localparam int unsigned BIT_VID = 14;
  localparam int unsigned BIT_PLLG = 13;
  localparam int unsigned BIT_P200 = 12;
  localparam int unsigned BIT_X87 = 11;
  localparam int unsigned BIT_C128 = 10;
  localparam int unsigned FLD_MSB = 7;

  localparam int unsigned ST_RESERVED = 0;
  localparam int unsigned ST_ILLEGAL = 1;
  localparam int unsigned ST_BITCLK = 2;
  localparam int unsigned ST_MODE_LO = 3;
  localparam int unsigned ST_HELD = 5;
  localparam int unsigned ST_SYNC_SEEN = 6;

  localparam logic [23:0] BITCLK_STEP_HZ = 24'h000960;
  localparam logic [23:0] PLUS_OFFSET_HZ = 24'h0000c8;
  localparam logic [3:0] BITCLK_MAX_CODE = 4'hb;
  localparam logic [3:0] CONV_MAX_CODE = 4'ha;
  localparam logic [3:0] ALL_ONES_CODE = 4'hf;
  localparam int unsigned MULT128_SHIFT = 7;
  localparam int unsigned EIGHT_SHIFT = 3;
  localparam logic [19:0] SEVEN = 20'h00007;

  localparam logic [23:0] HZ_48000 = 24'h00bb80;
  localparam logic [23:0] HZ_32000 = 24'h007d00;
  localparam logic [23:0] HZ_44100 = 24'h00ac44;
  localparam logic [23:0] HZ_29400 = 24'h0072d8;
  localparam logic [23:0] HZ_44056 = 24'h00ac18;
  localparam logic [4:0] DIV_SEVEN = 5'h07;

  typedef enum logic [1:0] {
    SC2_MASTER,
    SC2_SYNC_NORMAL,
    SC2_SYNC_VIDEO
  } sc2_mode_t;

  // expected conversion rate per high nibble, 0 when reserved
  function automatic logic [23:0] sc2_conv_code_hz(input logic [3:0] code);
    logic [23:0] base;
    base = 24'h0;
    unique case (code)
      4'h0, 4'h7: base = 24'h001c20;
      4'h1: base = 24'h0020d0;
      4'h2, 4'h8: base = 24'h002328;
      4'h3, 4'h9: base = 24'h002580;
      4'h4: base = 24'h002bc0;
      4'h5, 4'ha: base = 24'h002ee0;
      4'h6: base = 24'h003200;
      default: base = 24'h0;
    endcase
    if (code >= 4'h7 && code <= CONV_MAX_CODE) begin
      sc2_conv_code_hz = 24'((base << EIGHT_SHIFT) / 24'(SEVEN));
    end else begin
      sc2_conv_code_hz = base;
    end
  endfunction : sc2_conv_code_hz
endpackage : sc2_pkg

//--- pkg/sc2_dec_if.sv
interface sc2_dec_if;
  logic [7:0] field;
  logic ref_sel;
  logic vid;
  logic p200;
  logic x87;
  logic [15:0] rate;
  sc2_pkg::sc2_mode_t mode;
  logic bitclk_on;
  logic [23:0] bitclk_hz;
  logic [23:0] conv_hz;
  logic [23:0] base_hz;
  logic [4:0] divisor;
  logic pal;
  logic code_reserved;
  logic pair_illegal;

  modport ctrl (output field, ref_sel, vid, p200, x87, rate,
                input mode, bitclk_on, bitclk_hz, conv_hz, base_hz, divisor, pal, code_reserved, pair_illegal);
  modport dec (input field, ref_sel, vid, p200, x87, rate,
               output mode, bitclk_on, bitclk_hz, conv_hz, base_hz, divisor, pal, code_reserved, pair_illegal);
endinterface : sc2_dec_if

//--- logic/sc2_sync2ff.sv
module sc2_sync2ff #(
  parameter int unsigned W = 1
) (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_r;

  // first stage feeds only the second
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      meta_r <= '0;
      q_o <= '0;
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule : sc2_sync2ff

//--- logic/sc2_mode_decode.sv
module sc2_mode_decode (
  sc2_dec_if.dec d
);
  logic [3:0] lo_n;
  logic [3:0] hi_n;
  logic both_ones;
  logic lo_res;
  logic hi_res;
  logic [23:0] exp_hz;
  logic [23:0] sel_hz;
  logic [47:0] prod;
  logic [23:0] base;
  logic base_res;

  assign lo_n = d.field[3:0];
  assign hi_n = d.field[7:4];
  assign both_ones = (lo_n == sc2_pkg::ALL_ONES_CODE) && (hi_n == sc2_pkg::ALL_ONES_CODE);
  assign lo_res = (lo_n > sc2_pkg::BITCLK_MAX_CODE) && !both_ones;
  assign hi_res = (hi_n > sc2_pkg::CONV_MAX_CODE) && !both_ones;
  assign exp_hz = sc2_pkg::sc2_conv_code_hz(hi_n);

  always_comb begin
    if (!d.ref_sel) begin
      d.mode = sc2_pkg::SC2_MASTER;
    end else if (d.vid) begin
      d.mode = sc2_pkg::SC2_SYNC_VIDEO;
    end else begin
      d.mode = sc2_pkg::SC2_SYNC_NORMAL;
    end
  end

  // video base and divisor
  always_comb begin
    d.pal = d.field[sc2_pkg::FLD_MSB];
    d.divisor = 5'({1'b0, lo_n} + 5'h01);
    base_res = 1'b0;
    unique case (d.field[6:4])
      3'h0: base = sc2_pkg::HZ_48000;
      3'h1: base = sc2_pkg::HZ_32000;
      3'h2: base = sc2_pkg::HZ_44100;
      3'h3: base = sc2_pkg::HZ_29400;
      3'h4: base = sc2_pkg::HZ_48000;
      3'h5: base = sc2_pkg::HZ_44056;
      default: base = 24'h0;
    endcase
    if (d.field[6:4] > 3'h5 || (d.pal && d.field[6:4] > 3'h3)) begin
      base_res = 1'b1;
      base = 24'h0;
    end
    d.base_hz = base;
  end

  // flags pairs that software must not program
  always_comb begin
    d.pair_illegal = 1'b0;
    if (d.mode == sc2_pkg::SC2_SYNC_VIDEO) begin
      if ((d.field[6:4] == 3'h1 || d.field[6:4] == 3'h3) &&
          !(lo_n == 4'h0 || lo_n == 4'h1 || lo_n == 4'h3 || lo_n == 4'h4)) begin
        d.pair_illegal = 1'b1;
      end
      if (!d.pal && d.field[6:4] == 3'h0 && d.divisor == sc2_pkg::DIV_SEVEN) begin
        d.pair_illegal = 1'b1;
      end
    end
  end

  // conversion rate
  always_comb begin
    unique case (d.mode)
      sc2_pkg::SC2_MASTER: begin
        if (d.x87) begin
          d.conv_hz = 24'(({4'h0, d.rate} << sc2_pkg::EIGHT_SHIFT) / sc2_pkg::SEVEN);
        end else begin
          d.conv_hz = 24'(d.rate);
        end
      end
      sc2_pkg::SC2_SYNC_NORMAL: d.conv_hz = exp_hz;
      default: d.conv_hz = 24'(base / 24'(d.divisor));
    endcase
  end

  // bit clock
  always_comb begin
    sel_hz = 24'h0;
    prod = 48'h0;
    d.bitclk_on = 1'b0;
    d.bitclk_hz = 24'h0;
    d.code_reserved = 1'b0;
    if (d.mode == sc2_pkg::SC2_SYNC_VIDEO) begin
      d.code_reserved = base_res;
    end else begin
      d.code_reserved = lo_res || hi_res;
      if (both_ones) begin
        sel_hz = 24'(d.conv_hz << sc2_pkg::MULT128_SHIFT);
      end else if (!lo_res && !hi_res) begin
        sel_hz = 24'(({20'h0, lo_n} + 24'h1) * sc2_pkg::BITCLK_STEP_HZ);
        if (d.mode == sc2_pkg::SC2_MASTER && exp_hz != 24'h0) begin
          prod = 48'(sel_hz) * 48'(d.conv_hz);
          sel_hz = 24'(prod / 48'(exp_hz));
        end
      end
      if (!lo_res && !hi_res) begin
        d.bitclk_on = 1'b1;
        d.bitclk_hz = sel_hz + (d.p200 ? sc2_pkg::PLUS_OFFSET_HZ : 24'h0);
      end
    end
  end
endmodule : sc2_mode_decode

//--- testbench/sc2_mode_ctrl_monitor.sv
module sc2_mode_ctrl_monitor (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  input wire logic gen2_reference_select_o,
  input wire logic gen2_video_lock_enable_o,
  input wire logic gen2_phase_shift_enable_o,
  input wire logic gen1_regs_ignored_o,
  input wire logic gen2_conv_pin_multiplier_o,
  input wire logic gen2_bitclk_enable_o,
  input wire logic [23:0] gen2_bitclk_hz_o,
  input wire logic [23:0] gen2_conv_hz_o,
  input wire logic [23:0] gen2_conv_pin_hz_o,
  input wire logic [23:0] gen2_video_base_hz_o,
  input wire logic [4:0] gen2_video_divisor_o,
  input wire logic gen2_phase_align_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rstn_i);
  sequence s_taken;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  sequence s_one_wait;
    !avs_waitrequest_o ##1 avs_waitrequest_o;
  endsequence
  AST_ONE_WAIT:
    assert property (s_taken |=> s_one_wait) else $error("bus wait not one cycle");
  AST_SHIFT_MASTER:
    assert property (gen2_phase_shift_enable_o == !gen2_reference_select_o) else $error("shift enable wrong");
  AST_GEN1_IGNORED:
    assert property (gen1_regs_ignored_o == gen2_reference_select_o) else $error("gen1 ignore wrong");
  AST_VIDEO_NEEDS_REF:
    assert property (gen2_video_lock_enable_o |-> gen2_reference_select_o) else $error("video without sync");
  AST_VIDEO_NO_BITCLK:
    assert property (gen2_video_lock_enable_o |-> !gen2_bitclk_enable_o && gen2_bitclk_hz_o == 24'h0)
      else $error("bit clock in video");
  AST_CONV_PIN:
    assert property (gen2_conv_pin_hz_o == (gen2_conv_pin_multiplier_o ? 24'(gen2_conv_hz_o << 7) : gen2_conv_hz_o))
      else $error("conv pin rate wrong");
  AST_VIDEO_IDLE:
    assert property (!gen2_video_lock_enable_o |-> gen2_video_base_hz_o == 24'h0 && gen2_video_divisor_o == 5'h0)
      else $error("video fields outside video");
  AST_ALIGN_PULSE:
    assert property (gen2_phase_align_o |=> !gen2_phase_align_o) else $error("align pulse too long");
  AST_ALIGN_SYNC_ONLY:
    assert property (gen2_phase_align_o |-> gen2_reference_select_o) else $error("align in master mode");
endmodule : sc2_mode_ctrl_monitor

//--- testbench/sc2_sync_source.sv
module sc2_sync_source (
  input wire logic sys_clk_i,
  input wire logic run_i,
  input wire logic [7:0] half_i,
  output logic sync_o = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_r = 8'h0;
  // pin rests low between bursts; period far shorter than a line rate to keep runs short
  // no true line rate, so exactness of the raised-sync base is not judged
  always @(posedge sys_clk_i) begin
    if (!run_i) begin
      cnt_r <= 8'h0;
      sync_o <= 1'b0;
    end else if (cnt_r == half_i) begin
      cnt_r <= 8'h0;
      sync_o <= !sync_o;
    end else begin
      cnt_r <= cnt_r + 8'h1;
    end
  end
endmodule : sc2_sync_source

//--- testbench/sc2_mode_ctrl_bench.sv
module sc2_mode_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic power_down_pin_n_i = 1'b1;
  logic gen2_sync_input_i;
  logic [15:0] gen2_rate_reg_i = 16'hbb80;
  logic [3:0] avs_address_i = 4'h0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0] avs_byteenable_i = 4'h3;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o, gen2_reference_select_o, gen2_video_lock_enable_o, gen2_loop_gain_select_o;
  logic gen2_conv_pin_multiplier_o, gen2_phase_shift_enable_o, gen1_regs_ignored_o, gen2_bitclk_enable_o;
  logic [23:0] gen2_bitclk_hz_o, gen2_conv_hz_o, gen2_conv_pin_hz_o, gen2_video_base_hz_o;
  logic [4:0] gen2_video_divisor_o;
  logic gen2_video_pal_o, gen2_phase_align_o;
  logic sync_run = 1'b0;
  logic [31:0] rd_q;
  int fail_count = 0;
  int total_checks = 0;
  int cyc = 0;

  always #5 sys_clk_i = ~sys_clk_i;

  sc2_mode_ctrl u_sc2_mode_ctrl (.*);
  sc2_sync_source u_sc2_sync_source (.sys_clk_i(sys_clk_i), .run_i(sync_run), .half_i(8'h14),
    .sync_o(gen2_sync_input_i));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic chk1(input string nm, input logic e, input logic g);
    chk(nm, 32'(e), 32'(g));
  endtask : chk1

  // one access; two extra edges at the end so outputs read afterwards are settled
  task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d);
    avs_address_i <= a;
    avs_writedata_i <= {16'h0, d};
    avs_write_i <= w;
    avs_read_i <= !w;
    @(posedge sys_clk_i);
    while (avs_waitrequest_o !== 1'b0) @(posedge sys_clk_i);
    rd_q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
  endtask : bus

  task automatic rdchk(input string nm, input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 16'h0);
    chk(nm, e, rd_q);
  endtask : rdchk

  task automatic t_reset;
    rdchk("mode", 4'h0, 32'h00ff);
    chk("conv", 32'h00bb80, 32'(gen2_conv_hz_o));
    chk("bitclk", 32'h5dc000, 32'(gen2_bitclk_hz_o));
    chk("pin", 32'h00bb80, 32'(gen2_conv_pin_hz_o));
  endtask : t_reset

  task automatic t_master;
    gen2_rate_reg_i <= 16'h2580;
    bus(1'b1, 4'h0, 16'h4c93);
    rdchk("mode", 4'h0, 32'h4c93);
    chk1("video", 1'b0, gen2_video_lock_enable_o);
    chk("conv", 32'h002adb, 32'(gen2_conv_hz_o));
    chk("pin", 32'h156d80, 32'(gen2_conv_pin_hz_o));
    gen2_rate_reg_i <= 16'h4b00;
    bus(1'b1, 4'h0, 16'h0031);
    chk("scaled", 32'h002580, 32'(gen2_bitclk_hz_o));
    gen2_rate_reg_i <= 16'h2580;
    bus(1'b1, 4'h0, 16'h103b);
    chk("plus", 32'h007148, 32'(gen2_bitclk_hz_o));
  endtask : t_master

  task automatic t_bitclk;
    for (int i = 0; i < 15; i++) begin
      bus(1'b1, 4'h0, {12'h003, 4'(i)});
      chk("bitclk", (i < 12) ? 32'(i + 1) * 32'h960 : 32'h0, 32'(gen2_bitclk_hz_o));
      chk1("bitclk_on", i < 12, gen2_bitclk_enable_o);
    end
    rdchk("status", 4'h4, 32'h1);
  endtask : t_bitclk

  task automatic t_sync;
    int rises;
    int pulses;
    logic prev;
    rises = 0;
    pulses = 0;
    prev = 1'b0;
    gen2_rate_reg_i <= 16'h4b00;
    bus(1'b1, 4'h0, 16'ha83b);
    chk1("gen1_off", 1'b1, gen1_regs_ignored_o);
    chk1("gain", 1'b1, gen2_loop_gain_select_o);
    chk1("ref", 1'b1, gen2_reference_select_o);
    chk1("shift", 1'b0, gen2_phase_shift_enable_o);
    chk("conv", 32'h002580, 32'(gen2_conv_hz_o));
    chk("bitclk", 32'h007080, 32'(gen2_bitclk_hz_o));
    sync_run <= 1'b1;
    for (int i = 0; i < 260; i++) begin
      if (i == 200) sync_run <= 1'b0;
      rises += int'(gen2_sync_input_i && !prev);
      pulses += int'(gen2_phase_align_o);
      prev = gen2_sync_input_i;
      @(posedge sys_clk_i);
    end
    chk("aligns", 32'(rises), 32'(pulses));
    rdchk("period", 4'h8, 32'h2a);
    rdchk("status", 4'h4, 32'h4c);
  endtask : t_sync

  task automatic t_video;
    logic [7:0] f[8] = '{8'h03, 8'h14, 8'h21, 8'h30, 8'h40, 8'h51, 8'h82, 8'h94};
    logic [23:0] b[8] = '{sc2_pkg::HZ_48000, sc2_pkg::HZ_32000, sc2_pkg::HZ_44100, sc2_pkg::HZ_29400,
      sc2_pkg::HZ_48000, sc2_pkg::HZ_44056, sc2_pkg::HZ_48000, sc2_pkg::HZ_32000};
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, 4'h0, {8'hd0, f[i]});
      chk1("video", 1'b1, gen2_video_lock_enable_o);
      chk("base", 32'(b[i]), 32'(gen2_video_base_hz_o));
      chk("div", 32'(f[i][3:0]) + 32'h1, 32'(gen2_video_divisor_o));
      chk("conv", 32'(b[i]) / (32'(f[i][3:0]) + 32'h1), 32'(gen2_conv_hz_o));
      chk1("pal", f[i][7], gen2_video_pal_o);
      chk1("bitclk_on", 1'b0, gen2_bitclk_enable_o);
    end
    bus(1'b1, 4'h0, 16'hc006);
    bus(1'b0, 4'h4, 16'h0);
    chk1("illegal", 1'b1, rd_q[1]);
  endtask : t_video

  task automatic t_hold;
    power_down_pin_n_i <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    bus(1'b1, 4'h0, 16'h0031);
    rdchk("held", 4'h0, 32'h00ff);
    rdchk("held_st", 4'h4, 32'h64);
    power_down_pin_n_i <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    bus(1'b1, 4'h0, 16'h0031);
    rdchk("free", 4'h0, 32'h0031);
    rstn_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    rdchk("again", 4'h0, 32'h00ff);
    bus(1'b1, 4'hc, 16'hffff);
    rdchk("unmapped", 4'hc, 32'h0);
  endtask : t_hold

  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  // a hang ends here; real work needs about five hundred cycles
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      complete_run();
    end
  end

  initial begin
    repeat (12) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    t_reset();
    t_master();
    t_bitclk();
    t_sync();
    t_video();
    t_hold();
    complete_run();
  end
endmodule : sc2_mode_ctrl_bench

bind sc2_mode_ctrl sc2_mode_ctrl_monitor u_sc2_mode_ctrl_monitor (.*);
